/* verilog/amc_params.svh */
//======================================================================
// Behaviour
// - Conversion period 256/512/512|256/2560|512 master clocks
// - Rate pins 00 fast, 01 fine, 10 lean, 11 slow
// - Rate pins watched continuously, change acted on
// - SPI: ready_n held high after rate change, 129
// - Frame-sync: data forced zero after rate change
// - Resync low halts conversion, clears filter counters
// - Resync release restarts from cleared filter state
// - All channels share clock and resync timing
// - SPI: ready_n forced high when resync low
// - SPI: ready_n falls once settled, within 129
// - Frame-sync: data forced low when resync low
// - Frame-sync: zeros while settling, then valid data
// - Output rate scales with clock, 100 kHz minimum
// - Format pins pick SPI, frame-sync or modulator
// - SPI: ready_n falls when new result ready
//======================================================================
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

`define AMC_CLK_HZ        10000000
`define AMC_CLK_MIN_HZ    100000
`define AMC_PER_W         12
`define AMC_PER_256       12'd256
`define AMC_PER_512       12'd512
`define AMC_PER_2560      12'd2560
`define AMC_SET_W         8
`define AMC_SETTLE_SPI    8'd129
`define AMC_SETTLE_FS     8'd128
`define AMC_DATA_W        24
`define AMC_FIFO_DEPTH    32
`define AMC_PIN_W         7
`define AMC_PIN_RST       7'h40
`define AMC_PIN_RESYNC    6
`define AMC_PIN_FMT_HI    5
`define AMC_PIN_FMT_LO    3
`define AMC_PIN_DIV       2
`define AMC_PIN_RATE_HI   1
`define AMC_PIN_RATE_LO   0

`endif

/* verilog/amc_pkg.sv */
`default_nettype none
package amc_pkg;
	typedef enum logic [1:0] {
		RATE_FAST = 2'h0,
		RATE_FINE = 2'h1,
		RATE_LEAN = 2'h2,
		RATE_SLOW = 2'h3
	} amc_rate_t;

	typedef enum logic [3:0] {
		PROTO_SPI   = 4'h1,
		PROTO_FRAME = 4'h2,
		PROTO_MOD   = 4'h4,
		PROTO_NONE  = 4'h8
	} amc_proto_t;

	typedef enum logic [2:0] {
		ST_HALT   = 3'h1,
		ST_SETTLE = 3'h2,
		ST_VALID  = 3'h4
	} amc_state_t;
endpackage : amc_pkg
`default_nettype wire

/* verilog/amc_fifo_if.sv */
`default_nettype none
interface amc_fifo_if #(
	parameter int WIDTH = 24
) ();
	logic             push_valid;
	logic [WIDTH-1:0] push_data;
	logic             push_ready;
	logic             pop_valid;
	logic [WIDTH-1:0] pop_data;
	logic             pop_ready;
	logic             flush;

	modport store (
		input  push_valid,
		input  push_data,
		output push_ready,
		output pop_valid,
		output pop_data,
		input  pop_ready,
		input  flush
	);
	modport user (
		output push_valid,
		output push_data,
		input  push_ready,
		input  pop_valid,
		input  pop_data,
		output pop_ready,
		output flush
	);
endinterface : amc_fifo_if
`default_nettype wire

/* verilog/amc_fifo.sv */
`default_nettype none
module amc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input  wire logic clk,
	input  wire logic reset,
	amc_fifo_if.store fq
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic             not_full;
	logic             not_empty;
	logic             push_fire;
	logic             pop_fire;

	// Flags are registered so that ready never ripples from the reader
	assign fq.push_ready = not_full;
	assign fq.pop_valid  = not_empty;
	assign fq.pop_data   = mem[rd_idx];
	assign push_fire     = fq.push_valid && not_full;
	assign pop_fire      = fq.pop_ready && not_empty;

	always_comb begin
		next_count = count;
		if (push_fire && !pop_fire)
			next_count = count + CW'(1);
		else if (pop_fire && !push_fire)
			next_count = count - CW'(1);
	end

	always_ff @(posedge clk) begin
		if (push_fire)
			mem[wr_idx] <= fq.push_data;
	end

	always_ff @(posedge clk) begin
		if (reset || fq.flush) begin
			wr_idx    <= '0;
			rd_idx    <= '0;
			count     <= '0;
			not_full  <= 1'b1;
			not_empty <= 1'b0;
		end else begin
			if (push_fire)
				wr_idx <= wr_idx + AW'(1);
			if (pop_fire)
				rd_idx <= rd_idx + AW'(1);
			count     <= next_count;
			not_full  <= next_count != CW'(DEPTH);
			not_empty <= next_count != '0;
		end
	end
endmodule : amc_fifo
`default_nettype wire

/* verilog/amc_ctrl.sv */
`include "amc_params.svh"
`default_nettype none
module amc_ctrl (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [1:0]            mode_pins,
	input  wire logic                  clock_divide_select,
	input  wire logic [2:0]            format_pins,
	input  wire logic                  resync_n,
	input  wire logic                  result_valid,
	input  wire logic [`AMC_DATA_W-1:0] result_data,
	output logic                       result_ready,
	input  wire logic                  out_ready,
	output logic                       out_valid,
	output logic [`AMC_DATA_W-1:0]     out_data,
	output logic                       sample_ready_n,
	output logic                       conv_strobe,
	output logic                       filter_clear,
	output logic                       settled,
	output logic                       spi_active,
	output logic                       frame_active,
	output logic                       modulator_active
);
	//==================================================================
	// Decode helpers
	function automatic logic [`AMC_PER_W-1:0] amc_period(
		input amc_pkg::amc_rate_t r,
		input logic               div
	);
		logic [`AMC_PER_W-1:0] p;
		p = `AMC_PER_256;
		// Ratio is fixed per mode and divider setting, so output rate tracks the clock
		case (r)
			amc_pkg::RATE_FAST: p = `AMC_PER_256;
			amc_pkg::RATE_FINE: p = `AMC_PER_512;
			amc_pkg::RATE_LEAN: p = div ? `AMC_PER_512 : `AMC_PER_256;
			amc_pkg::RATE_SLOW: p = div ? `AMC_PER_2560 : `AMC_PER_512;
			default:            p = `AMC_PER_256;
		endcase
		return p;
	endfunction : amc_period

	function automatic amc_pkg::amc_proto_t amc_proto(
		input logic [2:0] f
	);
		amc_pkg::amc_proto_t q;
		q = amc_pkg::PROTO_NONE;
		// Code 111 is unused and parks the data path
		case (f)
			3'h0, 3'h1, 3'h2: q = amc_pkg::PROTO_SPI;
			3'h3, 3'h4, 3'h5: q = amc_pkg::PROTO_FRAME;
			3'h6:             q = amc_pkg::PROTO_MOD;
			default:          q = amc_pkg::PROTO_NONE;
		endcase
		return q;
	endfunction : amc_proto

	//==================================================================
	// Pin synchronisers
	logic [`AMC_PIN_W-1:0]  pin_meta;
	logic [`AMC_PIN_W-1:0]  pin_sync;
	logic                   resync_s;
	amc_pkg::amc_rate_t     pin_rate;
	logic                   pin_div;

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta <= `AMC_PIN_RST;
			pin_sync <= `AMC_PIN_RST;
		end else begin
			pin_meta <= {resync_n, format_pins, clock_divide_select,
				mode_pins};
			pin_sync <= pin_meta;
		end
	end

	assign resync_s = pin_sync[`AMC_PIN_RESYNC];
	assign pin_rate = amc_pkg::amc_rate_t'(
		pin_sync[`AMC_PIN_RATE_HI:`AMC_PIN_RATE_LO]);
	assign pin_div  = pin_sync[`AMC_PIN_DIV];

	//==================================================================
	// Rate selection, watched every cycle
	amc_pkg::amc_rate_t     rate;
	logic                   div;
	logic                   rate_change;
	amc_pkg::amc_proto_t    proto;
	amc_pkg::amc_proto_t    next_proto;
	logic [`AMC_PER_W-1:0]  period;

	// Divider change resettles in every mode, though it alters the rate only in lean and slow
	assign rate_change = (pin_rate != rate) || (pin_div != div);
	assign period      = amc_period(rate, div);
	assign next_proto  = amc_proto(
		pin_sync[`AMC_PIN_FMT_HI:`AMC_PIN_FMT_LO]);

	always_ff @(posedge clk) begin
		if (reset) begin
			rate  <= amc_pkg::RATE_FAST;
			div   <= 1'b0;
			proto <= amc_pkg::PROTO_SPI;
		end else begin
			rate  <= pin_rate;
			div   <= pin_div;
			proto <= next_proto;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			spi_active       <= 1'b0;
			frame_active     <= 1'b0;
			modulator_active <= 1'b0;
		end else begin
			spi_active       <= proto == amc_pkg::PROTO_SPI;
			frame_active     <= proto == amc_pkg::PROTO_FRAME;
			modulator_active <= proto == amc_pkg::PROTO_MOD;
		end
	end

	//==================================================================
	// Conversion timing
	logic [`AMC_PER_W-1:0] per_cnt;
	logic                  per_wrap;

	assign per_wrap = per_cnt == period - `AMC_PER_W'(1);

	// One strobe drives every channel's filter together
	always_ff @(posedge clk) begin
		if (reset || !resync_s || rate_change) begin
			per_cnt     <= '0;
			conv_strobe <= 1'b0;
		end else begin
			per_cnt     <= per_wrap ? '0 : per_cnt + `AMC_PER_W'(1);
			conv_strobe <= per_wrap;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			filter_clear <= 1'b1;
		else
			filter_clear <= !resync_s;
	end

	//==================================================================
	// Settling wait
	amc_pkg::amc_state_t   state;
	amc_pkg::amc_state_t   next_state;
	logic [`AMC_SET_W-1:0] settle_cnt;
	logic [`AMC_SET_W-1:0] settle_limit;
	logic [`AMC_SET_W-1:0] proto_limit;
	logic                  settle_load;

	// Follows the incoming format, so a joint pin change gets its own wait
	assign proto_limit = (next_proto == amc_pkg::PROTO_FRAME) ?
		`AMC_SETTLE_FS : `AMC_SETTLE_SPI;
	assign settle_load = (state == amc_pkg::ST_HALT && resync_s) ||
		(state != amc_pkg::ST_HALT && rate_change);

	always_comb begin
		next_state = state;
		case (state)
			amc_pkg::ST_HALT:
				if (resync_s)
					next_state = amc_pkg::ST_SETTLE;
			amc_pkg::ST_SETTLE:
				if (!rate_change && conv_strobe &&
					settle_cnt == `AMC_SET_W'(1))
					next_state = amc_pkg::ST_VALID;
			amc_pkg::ST_VALID:
				if (rate_change)
					next_state = amc_pkg::ST_SETTLE;
			default:
				next_state = amc_pkg::ST_HALT;
		endcase
		if (!resync_s)
			next_state = amc_pkg::ST_HALT;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state   <= amc_pkg::ST_HALT;
			settled <= 1'b0;
		end else begin
			state   <= next_state;
			settled <= next_state == amc_pkg::ST_VALID;
		end
	end

	// Counts conversions rather than clocks so one wait fits all rates
	always_ff @(posedge clk) begin
		if (reset) begin
			settle_cnt   <= '0;
			settle_limit <= `AMC_SETTLE_SPI;
		end else if (settle_load) begin
			settle_cnt   <= proto_limit;
			settle_limit <= proto_limit;
		end else if (conv_strobe && settle_cnt != '0) begin
			settle_cnt   <= settle_cnt - `AMC_SET_W'(1);
		end
	end

	//==================================================================
	// Result buffer and output gating
	amc_fifo_if #(.WIDTH(`AMC_DATA_W)) fq ();

	logic drop;
	logic take;
	logic next_out_valid;

	amc_fifo #(
		.WIDTH(`AMC_DATA_W),
		.DEPTH(`AMC_FIFO_DEPTH)
	) u_fifo (
		.clk   (clk),
		.reset (reset),
		.fq    (fq)
	);

	// Unsettled SPI results are discarded so stale data never surface
	assign drop = proto == amc_pkg::PROTO_MOD ||
		proto == amc_pkg::PROTO_NONE ||
		(proto == amc_pkg::PROTO_SPI && state != amc_pkg::ST_VALID);
	assign take = drop || !out_valid || out_ready;

	assign fq.push_valid = result_valid;
	assign fq.push_data  = result_data;
	assign fq.pop_ready  = take;
	assign fq.flush      = !resync_s || rate_change;
	assign result_ready  = fq.push_ready;

	always_comb begin
		next_out_valid = out_valid && !out_ready;
		if (take)
			next_out_valid = fq.pop_valid && !drop;
		if (!resync_s || rate_change)
			next_out_valid = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= next_out_valid;
			if (!resync_s || rate_change)
				out_data <= '0;
			else if (take && fq.pop_valid)
				out_data <= (state == amc_pkg::ST_VALID) ?
					fq.pop_data : '0;
		end
	end

	// Falls with each held SPI result, rises when the shifter takes it
	always_ff @(posedge clk) begin
		if (reset)
			sample_ready_n <= 1'b1;
		else
			sample_ready_n <= !(next_out_valid &&
				proto == amc_pkg::PROTO_SPI);
	end

	//==================================================================
	// Checks
	logic [`AMC_PER_W-1:0] gap;
	logic [`AMC_SET_W-1:0] conv_seen;
	logic                  strobe_seen;

	always_ff @(posedge clk) begin
		if (reset || !resync_s || rate_change || conv_strobe)
			gap <= '0;
		else
			gap <= gap + `AMC_PER_W'(1);
	end

	always_ff @(posedge clk) begin
		if (reset || settle_load)
			conv_seen <= '0;
		else if (conv_strobe && state == amc_pkg::ST_SETTLE)
			conv_seen <= conv_seen + `AMC_SET_W'(1);
	end

	// First strobe after a clear is one cycle late, so only later ones
	always_ff @(posedge clk) begin
		if (reset || !resync_s || rate_change)
			strobe_seen <= 1'b0;
		else if (conv_strobe)
			strobe_seen <= 1'b1;
	end

	a_strobe_spacing: assert property (
		@(posedge clk) disable iff (reset)
		conv_strobe && strobe_seen && gap != '0 &&
		$stable(rate) && $stable(div) |-> gap == period - `AMC_PER_W'(1)
	) else $error("conversion spacing wrong");

	a_sync_zero: assert property (
		@(posedge clk) disable iff (reset)
		!resync_s |=> out_data == '0
	) else $error("data not zeroed on resync");

	a_fast_rate: assert property (
		@(posedge clk) disable iff (reset)
		pin_sync[`AMC_PIN_RATE_HI:`AMC_PIN_RATE_LO] == 2'h0 && !pin_div
		|=> period == `AMC_PER_256
	) else $error("rate pins decoded wrongly");

	a_halt_no_conv: assert property (
		@(posedge clk) disable iff (reset)
		!resync_s |=> !conv_strobe && filter_clear
	) else $error("conversion not halted");

	a_restart_conv: assert property (
		@(posedge clk) disable iff (reset)
		$rose(resync_s) ##1 (resync_s && !rate_change)[*8]
		|-> state == amc_pkg::ST_SETTLE && !settled
	) else $error("restart not settling");

	a_ready_on_sync: assert property (
		@(posedge clk) disable iff (reset)
		!resync_s |=> sample_ready_n && !out_valid
	) else $error("ready not forced high on resync");

	a_fs_zero: assert property (
		@(posedge clk) disable iff (reset)
		out_valid && frame_active && !$past(settled) && $stable(proto)
		|-> out_data == '0
	) else $error("frame data not zero while settling");

	a_settle_count: assert property (
		@(posedge clk) disable iff (reset)
		$rose(settled) |-> conv_seen == settle_limit &&
			conv_seen <= `AMC_SETTLE_SPI
	) else $error("settling length wrong");

	a_change_resettle: assert property (
		@(posedge clk) disable iff (reset)
		rate_change && resync_s |=> !settled ##1 sample_ready_n
	) else $error("rate change did not resettle");

	a_ready_settled: assert property (
		@(posedge clk) disable iff (reset)
		!sample_ready_n |-> out_valid && $past(state) ==
			amc_pkg::ST_VALID
	) else $error("ready low without settled data");
endmodule : amc_ctrl
`default_nettype wire

/* sim/amc_host_model.sv */
`include "amc_params.svh"
`default_nettype none
module amc_host_model (
	input  wire logic                   clk,
	input  wire logic                   stall,
	input  wire logic                   out_valid,
	input  wire logic [`AMC_DATA_W-1:0] out_data,
	output var logic                    out_ready,
	output var logic                    took,
	output var logic [`AMC_DATA_W-1:0]  word,
	output var logic                    seen_one
);
	timeunit 1ns;
	timeprecision 1ns;
	//==========
	// Reader side
	initial begin
		out_ready = 1'b0;
		took = 1'b0;
		word = '0;
		seen_one = 1'b0;
	end
	// Ready moves only on the edge, so a stall lands cleanly
	always @(posedge clk) begin
		out_ready <= !stall;
		took <= out_valid && out_ready;
		if (out_valid && out_ready)
			word <= out_data;
		// A zero word means the data are still held back
		if (out_valid && out_ready)
			seen_one <= |out_data;
	end
endmodule : amc_host_model
`default_nettype wire

/* sim/test_adc_mode_clock_sync_control.sv */
`include "amc_params.svh"
`default_nettype none
module test_adc_mode_clock_sync_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = `AMC_DATA_W;
	logic         clk, reset, div, resync_n, res_valid, stall;
	logic [1:0]   mode;
	logic [2:0]   fmt;
	logic [W-1:0] res_data, out_data, word;
	logic         result_ready, out_ready, out_valid, sample_ready_n;
	logic         conv_strobe, filter_clear, settled, took, seen_one;
	logic         spi_active, frame_active, modulator_active;
	int           errors, comparisons;
	logic [1:0]   pm [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
	logic         pd [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	int           pp [6] = '{256, 512, 512, 256, 2560, 512};

	amc_ctrl u_amc_ctrl (
		.clk(clk), .reset(reset), .mode_pins(mode),
		.clock_divide_select(div), .format_pins(fmt),
		.resync_n(resync_n), .result_valid(res_valid),
		.result_data(res_data), .result_ready(result_ready),
		.out_ready(out_ready), .out_valid(out_valid),
		.out_data(out_data), .sample_ready_n(sample_ready_n),
		.conv_strobe(conv_strobe), .filter_clear(filter_clear),
		.settled(settled), .spi_active(spi_active),
		.frame_active(frame_active),
		.modulator_active(modulator_active)
	);
	amc_host_model u_amc_host_model (
		.clk(clk), .stall(stall), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready), .took(took),
		.word(word), .seen_one(seen_one)
	);

	//==========
	// Common tasks
	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic push(input logic [W-1:0] d);
		@(negedge clk);
		res_valid = 1'b1;
		res_data = d;
		@(negedge clk);
		res_valid = 1'b0;
	endtask : push

	task automatic take(output logic [W-1:0] w);
		int i;
		for (i = 0; i < 20 && took !== 1'b1; i++)
			@(negedge clk);
		w = (took === 1'b1) ? word : 'x;
		@(negedge clk);
	endtask : take

	// Counts conversions that end while still unsettled
	task automatic settle_count(output int n);
		int i;
		n = 0;
		for (i = 0; i < 40000 && settled !== 1'b1; i++) begin
			@(negedge clk);
			if (conv_strobe === 1'b1 && settled !== 1'b1)
				n++;
		end
	endtask : settle_count

	//==========
	// Scenarios
	task automatic t_format();
		int f;
		logic [2:0] e;
		for (f = 0; f < 8; f++) begin
			fmt = f[2:0];
			e = f < 3 ? 3'h4 : f < 6 ? 3'h2 : f == 6 ? 3'h1 : 3'h0;
			cyc(4);
			check("proto", {spi_active, frame_active, modulator_active},
				e);
		end
		fmt = 3'h0;
	endtask : t_format

	task automatic t_period(input int i);
		int k;
		mode = pm[i];
		div = pd[i];
		cyc(5);
		for (k = 0; k < 6000 && conv_strobe !== 1'b1; k++)
			@(negedge clk);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (conv_strobe !== 1'b1 && k < 3000);
		check("period", k, pp[i]);
	endtask : t_period

	task automatic t_sync_spi();
		int n;
		mode = 2'h0;
		cyc(5);
		resync_n = 1'b0;
		cyc(4);
		check("clear", filter_clear, 1);
		check("ready_n", sample_ready_n, 1);
		n = 0;
		repeat (600) begin
			@(negedge clk);
			if (conv_strobe === 1'b1)
				n++;
		end
		check("halted", n, 0);
		resync_n = 1'b1;
		cyc(4);
		check("clear", filter_clear, 0);
		settle_count(n);
		check("settle", n, 129);
	endtask : t_sync_spi

	// Reader stalls while the store fills, then drains in order
	task automatic t_fifo();
		int n, i;
		logic [W-1:0] w;
		stall = 1'b1;
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (result_ready !== 1'b1)
				break;
			res_valid = 1'b1;
			res_data = 24'ha00000 + n[W-1:0];
			n++;
		end
		res_valid = 1'b0;
		check("accepted", n == 32 || n == 33, 1);
		cyc(2);
		check("out_valid", out_valid, 1);
		check("ready_n", sample_ready_n, 0);
		stall = 1'b0;
		for (i = 0; i < n; i++) begin
			take(w);
			check("word", w, 24'ha00000 + i[W-1:0]);
		end
		cyc(3);
		check("ready_n", sample_ready_n, 1);
		stall = 1'b1;
		push(24'h123456);
		cyc(3);
		check("ready_n", sample_ready_n, 0);
		mode = 2'h1;
		cyc(5);
		check("ready_n", sample_ready_n, 1);
		check("settled", settled, 0);
		stall = 1'b0;
	endtask : t_fifo

	task automatic t_frame();
		int n;
		logic [W-1:0] w;
		fmt = 3'h3;
		mode = 2'h0;
		cyc(5);
		push(24'h7f00ff);
		take(w);
		check("hidden", w, 24'h0);
		check("seen_one", seen_one, 0);
		settle_count(n);
		check("settle", n >= 127 && n <= 128, 1);
		push(24'h800001);
		take(w);
		check("word", w, 24'h800001);
		check("seen_one", seen_one, 1);
		resync_n = 1'b0;
		cyc(4);
		check("zeroed", out_data, 0);
		check("clear", filter_clear, 1);
		resync_n = 1'b1;
		cyc(4);
	endtask : t_frame

	//==========
	// Clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Longest path is two settling waits, of 129 and 128 conversions
	initial begin
		#9000000;
		errors++;
		results();
	end

	initial begin
		errors = 0;
		comparisons = 0;
		reset = 1'b1;
		mode = 2'h0;
		div = 1'b1;
		fmt = 3'h0;
		resync_n = 1'b1;
		res_valid = 1'b0;
		res_data = '0;
		stall = 1'b0;
		cyc(10);
		reset = 1'b0;
		cyc(3);
		t_format();
		for (int i = 0; i < 6; i++)
			t_period(i);
		t_sync_spi();
		t_fifo();
		t_frame();
		results();
	end
endmodule : test_adc_mode_clock_sync_control
`default_nettype wire
